// >>> sdm_pkg.sv
// Shared constants of the step and direction motor drive control block
package sdm_pkg;

   // ****************************************************************
   // Timebase
   // ****************************************************************
   localparam int CLK_HZ             = 40_000_000;
   localparam int CYC_PER_US         = CLK_HZ / 1_000_000;
   localparam int IDLE_DELAY_US      = 400_000;
   localparam int IDLE_DELAY_CYCLES  = IDLE_DELAY_US * CYC_PER_US;
   localparam int STEP_MAX_HZ        = 200_000;
   localparam int STEP_MIN_CYCLES    = CLK_HZ / STEP_MAX_HZ;
   localparam int FLASH_ON_US        = 200_000;
   localparam int FLASH_OFF_US       = 200_000;
   localparam int FLASH_GAP_US       = 1_000_000;
   localparam int FLASH_ON_CYCLES    = FLASH_ON_US * CYC_PER_US;
   localparam int FLASH_OFF_CYCLES   = FLASH_OFF_US * CYC_PER_US;
   localparam int FLASH_GAP_CYCLES   = FLASH_GAP_US * CYC_PER_US;
   localparam int TIMER_W            = 26;

   // ****************************************************************
   // Register map
   // ****************************************************************
   localparam logic [7:0] ADDR_CONFIG     = 8'h00;
   localparam logic [7:0] ADDR_STATUS     = 8'h04;
   localparam logic [7:0] ADDR_POSITION   = 8'h08;
   localparam logic [7:0] ADDR_INT_STATUS = 8'h0c;
   localparam logic [7:0] ADDR_INT_MASK   = 8'h10;

   // CONFIG fields, a bit at one means the switch is on
   localparam int CFG_CUR_LSB   = 0;
   localparam int CFG_IDLE_BIT  = 3;
   localparam int CFG_MSTEP_LSB = 4;
   localparam int CFG_FAM_BIT   = 7;
   localparam logic [7:0] CONFIG_RESET = 8'h07;

   // STATUS fields
   localparam int ST_ENABLED   = 0;
   localparam int ST_REDUCED   = 1;
   localparam int ST_DIR       = 2;
   localparam int ST_FAULT_OC  = 3;
   localparam int ST_FAULT_OV  = 4;
   localparam int ST_LEVEL_LSB = 8;
   localparam int ST_DIV_LSB   = 16;

   // Interrupt event bits
   localparam int EV_OVERCURRENT = 0;
   localparam int EV_OVERVOLTAGE = 1;
   localparam int EV_STEP_RATE   = 2;
   localparam int EV_IDLE_REDUCE = 3;
   localparam int EV_W           = 4;
   localparam logic [EV_W-1:0] INT_MASK_RESET = 4'h0;

   // Microstep divisions, index {family, sw7, sw6, sw5}
   localparam int DIV_W = 8;
   localparam logic [DIV_W-1:0] DIV_RESET = 8'h7d;
   localparam logic [15:0][DIV_W-1:0] DIV_TABLE = {
      8'h00, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80,
      8'h05, 8'h0a, 8'h14, 8'h19, 8'h28, 8'h32, 8'h64, 8'h7d};
   localparam logic [3:0] MSTEP_INVALID = 4'hf;
   localparam int PHASE_W = 10;
   localparam int MICRO_PER_FULL_STEPS = 4;

   // Flash codes
   localparam logic [1:0] FLASH_NONE = 2'h0;
   localparam logic [1:0] FLASH_OC   = 2'h1;
   localparam logic [1:0] FLASH_OV   = 2'h2;

endpackage

// >>> sdm_flash.sv
// Fault indicator flash sequencer
`timescale 1ns/1ps
module sdm_flash
   import sdm_pkg::*;
#(
   parameter logic [TIMER_W-1:0] ON_CYCLES  = TIMER_W'(FLASH_ON_CYCLES),
   parameter logic [TIMER_W-1:0] OFF_CYCLES = TIMER_W'(FLASH_OFF_CYCLES),
   parameter logic [TIMER_W-1:0] GAP_CYCLES = TIMER_W'(FLASH_GAP_CYCLES)
)
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // Flash count request, zero for dark
   input  wire logic [1:0] code,
   // Indicator
   output logic            led
);

   typedef enum logic [3:0]
   {
      FL_IDLE = 4'b0001,
      FL_ON   = 4'b0010,
      FL_OFF  = 4'b0100,
      FL_GAP  = 4'b1000
   } sdm_flash_state_type;

   sdm_flash_state_type     state_r;
   sdm_flash_state_type     state_nxt;
   logic [TIMER_W-1:0]      timer_r;
   logic [TIMER_W-1:0]      timer_nxt;
   logic [1:0]              count_r;
   logic [1:0]              count_nxt;
   logic [1:0]              code_r;
   logic [1:0]              code_nxt;
   logic                    done;

   assign done = (timer_r == '0);

   // ****************************************************************
   // Sequencer, code is sampled once per group so a group never tears
   // ****************************************************************
   always_comb
   begin
      state_nxt = state_r;
      timer_nxt = done ? timer_r : timer_r - 1'b1;
      count_nxt = count_r;
      code_nxt  = code_r;
      unique case (state_r)
         FL_IDLE:
            if (code != FLASH_NONE)
            begin
               state_nxt = FL_ON;
               code_nxt  = code;
               count_nxt = 2'h1;
               timer_nxt = ON_CYCLES - 1'b1;
            end
         FL_ON:
            if (done)
            begin
               state_nxt = (count_r == code_r) ? FL_GAP : FL_OFF;
               timer_nxt = (count_r == code_r) ? GAP_CYCLES - 1'b1
                                               : OFF_CYCLES - 1'b1;
            end
         FL_OFF:
            if (done)
            begin
               state_nxt = FL_ON;
               count_nxt = count_r + 2'h1;
               timer_nxt = ON_CYCLES - 1'b1;
            end
         FL_GAP:
            if (done)
               state_nxt = FL_IDLE;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         state_r <= FL_IDLE;
         timer_r <= '0;
         count_r <= 2'h0;
         code_r  <= FLASH_NONE;
         led     <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         timer_r <= timer_nxt;
         count_r <= count_nxt;
         code_r  <= code_nxt;
         led     <= (state_nxt == FL_ON);
      end
   end

endmodule

// >>> sdm_drive_ctrl.sv
// Step and direction motor drive control with APB register file
//
// Contract
// RL1: One microstep per step input rising edge; falling edge ignored.
// RL2: Direction low steps one sense, high steps the other.
// RL3: Power stage on while enable active, off while inactive.
// RL4: An unconnected enable line counts as enabled.
// RL5: Three current switches pick one of eight levels; all on is lowest.
// RL6: Idle switch off sets standstill current to half running current.
// RL7: Idle switch on keeps standstill current at running current.
// RL8: Half current after the idle delay since last step; full on next.
// RL9: Four microstep switches pick binary or decimal division.
// RL10: Controller keeps step rate at or below the maximum input rate.
// RL11: Overcurrent enters protection and repeats one red flash.
// RL12: Overvoltage enters protection and repeats two red flashes.
// RL13: Both faults show only the overcurrent code; three never shown.
// RL14: All four microstep switches on is invalid; previous kept.
//
// Added by the designer: register access over APB and the register addresses.
`timescale 1ns/1ps
module sdm_drive_ctrl
   import sdm_pkg::*;
#(
   parameter logic [TIMER_W-1:0] IDLE_CYCLES = TIMER_W'(IDLE_DELAY_CYCLES),
   parameter logic [TIMER_W-1:0] FL_ON_CYC   = TIMER_W'(FLASH_ON_CYCLES),
   parameter logic [TIMER_W-1:0] FL_OFF_CYC  = TIMER_W'(FLASH_OFF_CYCLES),
   parameter logic [TIMER_W-1:0] FL_GAP_CYC  = TIMER_W'(FLASH_GAP_CYCLES)
)
(
   // Clock and reset
   input  wire logic                REF_CLK,
   input  wire logic                RESET_N,
   // APB slave
   input  wire logic                PSEL,
   input  wire logic                PENABLE,
   input  wire logic                PWRITE,
   input  wire logic [7:0]          PADDR,
   input  wire logic [31:0]         PWDATA,
   output logic      [31:0]         PRDATA,
   output logic                     PREADY,
   output logic                     PSLVERR,
   // Motion controller inputs
   input  wire logic                STEP_PULSE_INPUT,
   input  wire logic                DIRECTION_INPUT,
   input  wire logic                DRIVE_ENABLE_INPUT,
   input  wire logic                DRIVE_ENABLE_CONNECTED,
   // Fault comparators
   input  wire logic                OVERCURRENT_DETECT,
   input  wire logic                OVERVOLTAGE_DETECT,
   // Power stage
   output logic                     STAGE_ENABLE,
   output logic      [2:0]          CURRENT_LEVEL,
   output logic                     CURRENT_HALF,
   output logic      [PHASE_W-1:0]  PHASE_INDEX,
   // Indication
   output logic                     FAULT_LED,
   output logic                     IRQ
);

   // ****************************************************************
   // Declarations
   // ****************************************************************
   logic [7:0]          config_r;
   logic [EV_W-1:0]     int_status_r;
   logic [EV_W-1:0]     int_status_nxt;
   logic [EV_W-1:0]     int_mask_r;
   logic [EV_W-1:0]     events;
   logic [31:0]         position_r;
   logic [PHASE_W-1:0]  phase_r;
   logic [PHASE_W-1:0]  phase_nxt;
   logic [DIV_W-1:0]    div_r;
   logic                step_prev_r;
   logic                reduced_r;
   logic                fault_oc_r;
   logic                fault_ov_r;
   logic [TIMER_W-1:0]  idle_cnt_r;
   logic [TIMER_W-1:0]  rate_cnt_r;
   logic                first_step_r;
   logic                pready_r;
   logic [31:0]         prdata_r;
   logic                pslverr_r;

   logic                setup_phase;
   logic                wr_en;
   logic                addr_ok;
   logic [31:0]         rd_mux;
   logic                step_rise;
   logic                enabled;
   logic                step_take;
   logic [3:0]          mstep_sel;
   logic                mstep_valid;
   logic [PHASE_W-1:0]  phase_limit;
   logic                idle_expired;
   logic                reduce_now;
   logic                rate_violation;
   logic [1:0]          flash_code;
   logic [2:0]          level;

   // ****************************************************************
   // APB decode
   // ****************************************************************
   assign setup_phase = PSEL & ~PENABLE;
   assign wr_en       = PSEL & PENABLE & pready_r & PWRITE & addr_ok;
   assign addr_ok     = (PADDR == ADDR_CONFIG)     |
                        (PADDR == ADDR_STATUS)     |
                        (PADDR == ADDR_POSITION)   |
                        (PADDR == ADDR_INT_STATUS) |
                        (PADDR == ADDR_INT_MASK);
   assign rd_mux =
      (PADDR == ADDR_CONFIG)     ? {24'h000000, config_r} :
      (PADDR == ADDR_STATUS)     ? {8'h00, div_r, 5'h00, level,
                                    3'h0, fault_ov_r, fault_oc_r,
                                    DIRECTION_INPUT, reduced_r,
                                    STAGE_ENABLE} :
      (PADDR == ADDR_POSITION)   ? position_r :
      (PADDR == ADDR_INT_STATUS) ? {28'h0000000, int_status_r} :
      (PADDR == ADDR_INT_MASK)   ? {28'h0000000, int_mask_r} :
                                   32'h00000000;

   // ****************************************************************
   // Step, direction and enable
   // ****************************************************************
   assign step_rise = STEP_PULSE_INPUT & ~step_prev_r; // RL1
   assign enabled   = ~DRIVE_ENABLE_CONNECTED | DRIVE_ENABLE_INPUT; // RL4
   // Steps are dropped while the stage is off, so position stays honest
   assign step_take = step_rise & STAGE_ENABLE; // RL3

   // ****************************************************************
   // Switch decode
   // ****************************************************************
   assign level = ~config_r[CFG_CUR_LSB +: 3]; // RL5
   assign mstep_sel   = {config_r[CFG_FAM_BIT],
                         config_r[CFG_MSTEP_LSB +: 3]};
   assign mstep_valid = (mstep_sel != MSTEP_INVALID); // RL14
   assign phase_limit = PHASE_W'(div_r) * PHASE_W'(MICRO_PER_FULL_STEPS);
   assign phase_nxt =
      DIRECTION_INPUT ? ((phase_r == '0) ? phase_limit - 1'b1
                                         : phase_r - 1'b1)
                      : ((phase_r >= phase_limit - 1'b1) ? '0
                                         : phase_r + 1'b1); // RL2

   // ****************************************************************
   // Idle reduction and rate check
   // ****************************************************************
   assign idle_expired = (idle_cnt_r >= IDLE_CYCLES - 1'b1);
   assign reduce_now   = ~config_r[CFG_IDLE_BIT] & idle_expired; // RL6 RL7
   // Spacing of one period of the maximum rate or less is flagged, not refused
   assign rate_violation = step_rise & ~first_step_r &
                           (rate_cnt_r < TIMER_W'(STEP_MIN_CYCLES)); // RL10

   // ****************************************************************
   // Faults and interrupts
   // ****************************************************************
   assign flash_code = fault_oc_r ? FLASH_OC :
                       fault_ov_r ? FLASH_OV : FLASH_NONE; // RL13
   assign events[EV_OVERCURRENT] = OVERCURRENT_DETECT & ~fault_oc_r;
   assign events[EV_OVERVOLTAGE] = OVERVOLTAGE_DETECT & ~fault_ov_r;
   assign events[EV_STEP_RATE]   = rate_violation;
   assign events[EV_IDLE_REDUCE] = reduce_now & ~reduced_r;
   // A new event in the clearing cycle survives the write
   assign int_status_nxt = (wr_en && PADDR == ADDR_INT_STATUS)
                         ? ((int_status_r & ~PWDATA[EV_W-1:0]) | events)
                         : (int_status_r | events);

   // ****************************************************************
   // Bus registers
   // ****************************************************************
   always_ff @(posedge REF_CLK)
   begin
      if (!RESET_N)
      begin
         pready_r   <= 1'b0;
         prdata_r   <= 32'h00000000;
         pslverr_r  <= 1'b0;
         config_r   <= CONFIG_RESET;
         int_mask_r <= INT_MASK_RESET;
      end
      else
      begin
         pready_r  <= setup_phase;
         prdata_r  <= setup_phase ? rd_mux : prdata_r;
         pslverr_r <= setup_phase & ~addr_ok;
         if (wr_en && PADDR == ADDR_CONFIG)
            config_r <= PWDATA[7:0];
         if (wr_en && PADDR == ADDR_INT_MASK)
            int_mask_r <= PWDATA[EV_W-1:0];
      end
   end

   // ****************************************************************
   // Motion state
   // ****************************************************************
   always_ff @(posedge REF_CLK)
   begin
      if (!RESET_N)
      begin
         step_prev_r  <= 1'b0;
         position_r   <= 32'h00000000;
         phase_r      <= '0;
         div_r        <= DIV_RESET;
         first_step_r <= 1'b1;
         rate_cnt_r   <= '0;
      end
      else
      begin
         step_prev_r <= STEP_PULSE_INPUT;
         if (mstep_valid)
            div_r <= DIV_TABLE[mstep_sel]; // RL9
         if (step_take)
         begin
            position_r <= DIRECTION_INPUT ? position_r - 32'h00000001
                                          : position_r + 32'h00000001; // RL2
            phase_r    <= phase_nxt; // RL1
         end
         else if (phase_r >= phase_limit)
            phase_r <= '0;
         if (step_rise)
         begin
            rate_cnt_r   <= '0;
            first_step_r <= 1'b0;
         end
         else if (rate_cnt_r != {TIMER_W{1'b1}})
            rate_cnt_r <= rate_cnt_r + 1'b1;
      end
   end

   // ****************************************************************
   // Current control and protection
   // ****************************************************************
   always_ff @(posedge REF_CLK)
   begin
      if (!RESET_N)
      begin
         idle_cnt_r    <= '0;
         reduced_r     <= 1'b0;
         fault_oc_r    <= 1'b0;
         fault_ov_r    <= 1'b0;
         int_status_r  <= '0;
         STAGE_ENABLE  <= 1'b0;
         CURRENT_LEVEL <= 3'h0;
         CURRENT_HALF  <= 1'b0;
         PHASE_INDEX   <= '0;
         IRQ           <= 1'b0;
      end
      else
      begin
         if (step_rise)
            idle_cnt_r <= '0; // RL8
         else if (!idle_expired)
            idle_cnt_r <= idle_cnt_r + 1'b1;
         reduced_r <= step_rise ? 1'b0 : reduce_now; // RL8
         // Protection latches until reset, as a supply fault may recur
         if (OVERCURRENT_DETECT)
            fault_oc_r <= 1'b1; // RL11
         if (OVERVOLTAGE_DETECT)
            fault_ov_r <= 1'b1; // RL12
         int_status_r  <= int_status_nxt;
         STAGE_ENABLE  <= enabled & ~fault_oc_r & ~fault_ov_r &
                          ~OVERCURRENT_DETECT & ~OVERVOLTAGE_DETECT; // RL3
         CURRENT_LEVEL <= level; // RL5
         CURRENT_HALF  <= step_rise ? 1'b0 : reduce_now; // RL6 RL7
         PHASE_INDEX   <= phase_r;
         IRQ           <= |(int_status_nxt & int_mask_r);
      end
   end

   // ****************************************************************
   // Fault indicator
   // ****************************************************************
   sdm_flash #(
      .ON_CYCLES  (FL_ON_CYC),
      .OFF_CYCLES (FL_OFF_CYC),
      .GAP_CYCLES (FL_GAP_CYC)
   ) u_flash (
      .clk   (REF_CLK),
      .rst_n (RESET_N),
      .code  (flash_code), // RL11 RL12 RL13
      .led   (FAULT_LED)
   );

   assign PRDATA  = prdata_r;
   assign PREADY  = pready_r;
   assign PSLVERR = pslverr_r;

endmodule

// >>> sdm_drive_ctrl_props.sv
// Port checks of the drive control block
`timescale 1ns/1ps
module sdm_drive_ctrl_props
   import sdm_pkg::*;
#(
   parameter logic [TIMER_W-1:0] IDLE_CYCLES = TIMER_W'(IDLE_DELAY_CYCLES)
)
(
   // Clock, reset and bus
   input wire logic               REF_CLK,
   input wire logic               RESET_N,
   input wire logic               PSEL,
   input wire logic               PENABLE,
   input wire logic               PREADY,
   input wire logic               PSLVERR,
   // Motion and fault inputs
   input wire logic               STEP_PULSE_INPUT,
   input wire logic               DRIVE_ENABLE_INPUT,
   input wire logic               DRIVE_ENABLE_CONNECTED,
   input wire logic               OVERCURRENT_DETECT,
   input wire logic               OVERVOLTAGE_DETECT,
   // Stage outputs
   input wire logic               STAGE_ENABLE,
   input wire logic               CURRENT_HALF,
   input wire logic [PHASE_W-1:0] PHASE_INDEX,
   input wire logic               FAULT_LED
);
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (!RESET_N);

   // **********
   // Cycles since the latest accepted step
   // **********
   // Only steps taken while enabled restart it, as ignored steps may not
   logic [31:0] idle_cnt_r;
   logic        step_d_r;
   always_ff @(posedge REF_CLK)
   begin
      step_d_r <= STEP_PULSE_INPUT;
      if (!RESET_N || (STEP_PULSE_INPUT && !step_d_r && STAGE_ENABLE))
         idle_cnt_r <= 32'h0;
      else if (idle_cnt_r != 32'hffffffff)
         idle_cnt_r <= idle_cnt_r + 32'h1;
   end

   // **********
   // Assertions
   // **********
   chk_ready_after_setup: assert property (PSEL && !PENABLE |=> PREADY)
      else $error("No PREADY after setup");
   chk_ready_one_cycle: assert property (PREADY |=> !PREADY)
      else $error("PREADY longer than one cycle");
   chk_err_with_ready: assert property (PSLVERR |-> PREADY)
      else $error("PSLVERR without PREADY");
   chk_stage_disabled: assert property (
      (DRIVE_ENABLE_CONNECTED && !DRIVE_ENABLE_INPUT) [*3] |-> !STAGE_ENABLE)
      else $error("Stage on while enable inactive");
   chk_oc_stage_off: assert property (
      OVERCURRENT_DETECT |=> !STAGE_ENABLE)
      else $error("Stage on during overcurrent");
   chk_ov_stage_off: assert property (
      OVERVOLTAGE_DETECT |=> !STAGE_ENABLE)
      else $error("Stage on during overvoltage");
   chk_led_only_fault: assert property (
      FAULT_LED |-> !STAGE_ENABLE)
      else $error("Fault light while stage on");
   chk_step_moves_phase: assert property (
      $rose(STEP_PULSE_INPUT) && STAGE_ENABLE
         |-> ##2 PHASE_INDEX != $past(PHASE_INDEX, 2))
      else $error("Step did not move phase");
   chk_fall_no_move: assert property (
      $fell(STEP_PULSE_INPUT) |-> ##2 $stable(PHASE_INDEX))
      else $error("Falling step moved phase");
   chk_half_cleared: assert property (
      $rose(STEP_PULSE_INPUT) && STAGE_ENABLE |=> !CURRENT_HALF)
      else $error("Step left current reduced");
   chk_idle_delay: assert property (
      $rose(CURRENT_HALF) |-> idle_cnt_r >= 32'(IDLE_CYCLES) - 32'h2)
      else $error("Current reduced too early");
endmodule

bind sdm_drive_ctrl sdm_drive_ctrl_props #(.IDLE_CYCLES(IDLE_CYCLES)) u_props (
   .REF_CLK, .RESET_N, .PSEL, .PENABLE, .PREADY, .PSLVERR,
   .STEP_PULSE_INPUT, .DRIVE_ENABLE_INPUT, .DRIVE_ENABLE_CONNECTED,
   .OVERCURRENT_DETECT, .OVERVOLTAGE_DETECT, .STAGE_ENABLE,
   .CURRENT_HALF, .PHASE_INDEX, .FAULT_LED);

// >>> sdm_motion_model.sv
// Motion controller model that drives step and direction
`timescale 1ns/1ps
module sdm_motion_model
   import sdm_pkg::*;
(
   // Clock
   input wire logic clk,
   // Step link
   output logic     step,
   output logic     dir
);
   initial
   begin
      step = 1'b0;
      dir  = 1'b0;
   end

   // **********
   // Burst of steps, gap in cycles between rising edges
   // **********
   task automatic burst(input int n, input int gap, input logic sense);
      @(posedge clk);
      dir <= sense;
      // Direction settles well before the first rising edge
      repeat (STEP_MIN_CYCLES) @(posedge clk);
      for (int i = 0; i < n; i++)
      begin
         step <= 1'b1;
         repeat (gap / 2) @(posedge clk);
         step <= 1'b0;
         repeat (gap - gap / 2) @(posedge clk);
      end
   endtask
endmodule

// >>> testbench.sv
// Self-checking bench of the drive control block
`timescale 1ns/1ps
module testbench
   import sdm_pkg::*;
;
   // Short idle delay and flash times keep the run brief
   localparam int IDLE = 400;
   logic        clk, rst_n, psel, penable, pwrite, ena, ena_con, oc, ov;
   logic [7:0]  paddr;
   logic [31:0] pwdata, rdat;
   logic        rerr;
   wire logic [31:0]        prdata;
   wire logic               pready, pslverr, step, dir, stage, half;
   wire logic               led, irq;
   wire logic [2:0]         level;
   wire logic [PHASE_W-1:0] phase;
   int          num_errors = 0;
   int          n_compared = 0;
   int          cyc = 0;

   sdm_drive_ctrl #(.IDLE_CYCLES(TIMER_W'(IDLE)), .FL_ON_CYC(TIMER_W'(5)),
      .FL_OFF_CYC(TIMER_W'(5)), .FL_GAP_CYC(TIMER_W'(20))) u_sdm_drive_ctrl (
      .REF_CLK(clk), .RESET_N(rst_n), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .STEP_PULSE_INPUT(step),
      .DIRECTION_INPUT(dir), .DRIVE_ENABLE_INPUT(ena),
      .DRIVE_ENABLE_CONNECTED(ena_con), .OVERCURRENT_DETECT(oc),
      .OVERVOLTAGE_DETECT(ov), .STAGE_ENABLE(stage), .CURRENT_LEVEL(level),
      .CURRENT_HALF(half), .PHASE_INDEX(phase), .FAULT_LED(led), .IRQ(irq));
   sdm_motion_model u_sdm_motion_model (.clk(clk), .step(step), .dir(dir));

   always #12.5 clk = ~clk;

   // **********
   // Bus, compare and run control
   // **********
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
         @(posedge clk);
      rdat = prdata;
      rerr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      n_compared++;
      if (g !== e)
      begin
         num_errors++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic rdchk(input string nm, input logic [7:0] a,
                        input logic [31:0] m, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(nm, e, rdat & m);
   endtask

   task automatic do_reset;
      rst_n <= 1'b0;
      oc    <= 1'b0;
      ov    <= 1'b0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
   endtask

   task automatic stop_test;
      if (num_errors == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // A hang counts as a mismatch
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         num_errors++;
         stop_test;
      end
   end

   // **********
   // Scenarios
   // **********
   task automatic t_regs;
      rdchk("config", ADDR_CONFIG, 32'hff, 32'h07);
      rdchk("int_mask", ADDR_INT_MASK, 32'hf, 32'h0);
      rdchk("division", ADDR_STATUS, 32'hff0000, 32'd125 << 16);
      chk("level", 32'h0, 32'(level));
      apb(1'b1, 8'h14, 32'h1);
      chk("unmapped_err", 32'h1, 32'(rerr));
      rdchk("unmapped", 8'h14, 32'hffffffff, 32'h0);
      chk("unmapped_err", 32'h1, 32'(rerr));
   endtask

   task automatic t_current;
      for (int c = 0; c < 8; c++)
      begin
         apb(1'b1, ADDR_CONFIG, 32'(c));
         repeat (2) @(posedge clk);
         chk("level", 32'(7 - c), 32'(level));
      end
   endtask

   task automatic t_mstep;
      logic [7:0] dec [8] = '{8'd125, 8'd100, 8'd50, 8'd40,
                              8'd25, 8'd20, 8'd10, 8'd5};
      logic [7:0] e;
      for (int v = 0; v < 15; v++)
      begin
         e = v[3] ? 8'h1 << (7 - v[2:0]) : dec[v[2:0]];
         apb(1'b1, ADDR_CONFIG, 32'(v << 4));
         rdchk("division", ADDR_STATUS, 32'hff0000, 32'(e) << 16);
      end
      apb(1'b1, ADDR_CONFIG, 32'hf0);
      rdchk("division", ADDR_STATUS, 32'hff0000, 32'h20000);
   endtask

   task automatic t_steps;
      logic [31:0] p;
      apb(1'b1, ADDR_CONFIG, 32'h0f);
      apb(1'b0, ADDR_POSITION, 32'h0);
      p = rdat;
      u_sdm_motion_model.burst(3, STEP_MIN_CYCLES, 1'b0);
      apb(1'b1, ADDR_POSITION, 32'h1234);
      rdchk("position", ADDR_POSITION, '1, p + 32'd3);
      u_sdm_motion_model.burst(2, STEP_MIN_CYCLES, 1'b1);
      rdchk("position", ADDR_POSITION, '1, p + 32'd1);
      ena <= 1'b0;
      u_sdm_motion_model.burst(2, STEP_MIN_CYCLES, 1'b0);
      chk("stage_enable", 32'h0, 32'(stage));
      rdchk("position", ADDR_POSITION, '1, p + 32'd1);
      ena_con <= 1'b0;
      u_sdm_motion_model.burst(1, STEP_MIN_CYCLES, 1'b0);
      chk("stage_enable", 32'h1, 32'(stage));
      rdchk("position", ADDR_POSITION, '1, p + 32'd2);
   endtask

   task automatic t_idle;
      apb(1'b1, ADDR_CONFIG, 32'h07);
      u_sdm_motion_model.burst(1, STEP_MIN_CYCLES, 1'b0);
      chk("half", 32'h0, 32'(half));
      apb(1'b1, ADDR_INT_STATUS, 32'hf);
      repeat (IDLE - 230) @(posedge clk);
      chk("half", 32'h0, 32'(half));
      repeat (40) @(posedge clk);
      chk("half", 32'h1, 32'(half));
      rdchk("idle_event", ADDR_INT_STATUS, 32'h8, 32'h8);
      u_sdm_motion_model.burst(1, STEP_MIN_CYCLES, 1'b0);
      chk("half", 32'h0, 32'(half));
      apb(1'b1, ADDR_CONFIG, 32'h0f);
      repeat (IDLE + 40) @(posedge clk);
      chk("half", 32'h0, 32'(half));
   endtask

   task automatic t_irq;
      apb(1'b1, ADDR_INT_STATUS, 32'hf);
      apb(1'b1, ADDR_INT_MASK, 32'h4);
      chk("irq", 32'h0, 32'(irq));
      // Steps closer than the minimum spacing, on purpose
      u_sdm_motion_model.burst(2, STEP_MIN_CYCLES / 4, 1'b0);
      rdchk("rate_event", ADDR_INT_STATUS, 32'h4, 32'h4);
      chk("irq", 32'h1, 32'(irq));
      apb(1'b1, ADDR_INT_STATUS, 32'h4);
      repeat (2) @(posedge clk);
      chk("irq", 32'h0, 32'(irq));
      apb(1'b1, ADDR_INT_MASK, 32'h0);
      u_sdm_motion_model.burst(2, STEP_MIN_CYCLES / 4, 1'b0);
      rdchk("rate_event", ADDR_INT_STATUS, 32'h4, 32'h4);
      chk("irq", 32'h0, 32'(irq));
   endtask

   // Faults latch, so each case starts from reset
   task automatic t_fault(input logic a, input logic b, input int n);
      int   k, cnt;
      logic prev;
      do_reset;
      @(posedge clk);
      oc <= a;
      ov <= b;
      repeat (3) @(posedge clk);
      chk("stage_enable", 32'h0, 32'(stage));
      for (k = 0; led !== 1'b1 && k < 200; k++)
         @(posedge clk);
      cnt  = (led === 1'b1) ? 1 : 0;
      prev = led;
      repeat (22)
      begin
         @(posedge clk);
         if (led === 1'b1 && prev !== 1'b1)
            cnt++;
         prev = led;
      end
      chk("flash_count", 32'(n), 32'(cnt));
   endtask

   initial
   begin
      clk     = 1'b0;
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 8'h00;
      pwdata  = 32'h0;
      ena     = 1'b1;
      ena_con = 1'b1;
      do_reset;
      t_regs;
      t_current;
      t_mstep;
      t_steps;
      t_idle;
      t_irq;
      t_fault(1'b1, 1'b0, 1);
      t_fault(1'b0, 1'b1, 2);
      t_fault(1'b1, 1'b1, 1);
      do_reset;
      stop_test;
   end
endmodule
